// ---- acc_exec_pkg.sv ----
// package for the accumulator execute unit: opcodes, flag layout, timing
// assumes nothing beyond a systemverilog compiler
package acc_exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [7:0] ADJ_LOW = 8'h06;
  localparam logic [7:0] ADJ_HIGH = 8'h60;
  localparam logic [1:0] CYCLES_SHORT = 2'h1;
  localparam logic [1:0] CYCLES_BRANCH = 2'h2;

  typedef enum logic [4:0] {
    op_idle_op = 5'h00,
    op_invert_to_acc = 5'h01,
    op_bcd_adjust_store = 5'h02,
    op_subtract_one_memory = 5'h03,
    op_subtract_one_to_acc = 5'h04,
    op_add_one_memory = 5'h05,
    op_add_one_to_acc = 5'h06,
    op_jump_absolute = 5'h07,
    op_copy_mem_to_acc = 5'h08,
    op_copy_imm_to_acc = 5'h09,
    op_copy_acc_to_mem = 5'h0a,
    op_union_mem_to_acc = 5'h0b,
    op_union_imm_to_acc = 5'h0c,
    op_bitwise_union_to_memory = 5'h0d,
    op_pop_program_counter = 5'h0e,
    op_pop_with_value = 5'h0f,
    op_interrupt_exit = 5'h10,
    op_rotate_left = 5'h11,
    op_rotate_left_to_acc = 5'h12,
    op_rotate_left_via_carry = 5'h13,
    op_rotate_left_via_carry_to_acc = 5'h14,
    op_rotate_right = 5'h15,
    op_power_down = 5'h16
  } opcode_e;

  typedef struct packed {
    opcode_e op;
    logic [DATA_W-1:0] mem;
    logic [DATA_W-1:0] imm;
    logic [PC_W-1:0] addr;
    logic [PC_W-1:0] stack_top;
  } instr_s;

  typedef struct packed {
    logic zero;
    logic carry;
    logic nibble_carry;
  } flags_s;

  typedef enum logic [1:0] {
    st_exec = 2'b01,
    st_dummy = 2'b10
  } exec_state_e;
endpackage

// ---- accumulator_execute_unit.sv ----
// accumulator execute unit: one instruction per valid, results held in flops
// assumes memory operand and stack top are presented with the instruction
`timescale 1ns/1ns
`default_nettype none
module accumulator_execute_unit
  import acc_exec_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // instruction in
  input wire logic i_valid,
  input var instr_s i_instr,
  input wire logic i_irq_pending,
  // results
  output logic o_ready,
  output logic [DATA_W-1:0] o_acc,
  output var flags_s o_flags,
  output logic o_mem_we,
  output logic [DATA_W-1:0] o_mem_wdata,
  output logic o_pc_load,
  output logic [PC_W-1:0] o_pc_value,
  output logic o_stack_pop,
  output logic o_irq_vector_take,
  output logic o_global_irq_enable,
  output logic o_sleep_entry_flag,
  output logic o_watchdog_expiry_flag,
  output logic o_watchdog_clear,
  output logic o_clock_stop
);

  // ----------------------------------------
  // decode and datapath
  // ----------------------------------------
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  exec_state_e state_reg;
  logic [DATA_W-1:0] acc_reg;
  flags_s flags_reg;
  logic mem_we_reg;
  logic [DATA_W-1:0] mem_wdata_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_value_reg;
  logic pop_reg;
  logic irq_take_reg;
  logic gie_reg;
  logic sleep_reg;
  logic wdt_exp_reg;
  logic wdt_clr_reg;
  logic clk_stop_reg;
  logic ready_reg;

  wire logic take = i_valid && state_reg == st_exec && !clk_stop_reg;
  wire logic [DATA_W-1:0] m = i_instr.mem;
  wire logic [DATA_W-1:0] inv_val = ~m;
  wire logic [DATA_W-1:0] dec_val = m - 8'h01;
  wire logic [DATA_W-1:0] inc_val = m + 8'h01;
  wire logic [DATA_W-1:0] or_mem_val = acc_reg | m;
  wire logic [DATA_W-1:0] or_imm_val = acc_reg | i_instr.imm;
  wire logic [DATA_W-1:0] rl_val = {m[6:0], m[7]};
  wire logic [DATA_W-1:0] rlc_val = {m[6:0], flags_reg.carry};
  wire logic [DATA_W-1:0] rr_val = {m[0], m[7:1]};
  wire logic low_fix = acc_reg[3:0] > BCD_LIMIT || flags_reg.nibble_carry;
  wire logic high_fix = acc_reg[7:4] > BCD_LIMIT || flags_reg.carry;
  wire logic [DATA_W:0] daa_sum = {1'b0, acc_reg} + {1'b0, low_fix ? ADJ_LOW : 8'h00}
                                  + {1'b0, high_fix ? ADJ_HIGH : 8'h00};
  // carry after adjust is set by a high digit above 9 before adjust or by an incoming carry
  wire logic daa_carry = flags_reg.carry || high_fix || daa_sum[DATA_W];
  wire opcode_e op = i_instr.op;
  wire logic is_branch = op == op_jump_absolute || op == op_pop_program_counter
                         || op == op_pop_with_value || op == op_interrupt_exit;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  logic [DATA_W-1:0] acc_next;
  flags_s flags_next;
  logic mem_we_next;
  logic [DATA_W-1:0] mem_wdata_next;
  logic gie_next;
  logic sleep_next;
  logic wdt_exp_next;
  logic stop_next;

  always_comb begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    mem_we_next = 1'b0;
    mem_wdata_next = mem_wdata_reg;
    gie_next = gie_reg;
    sleep_next = sleep_reg;
    wdt_exp_next = wdt_exp_reg;
    stop_next = clk_stop_reg;
    if (take) begin
      case (op)
        op_invert_to_acc: begin
          acc_next = inv_val;
          flags_next.zero = is_zero(inv_val);
        end
        op_bcd_adjust_store: begin
          mem_we_next = 1'b1;
          mem_wdata_next = daa_sum[DATA_W-1:0];
          flags_next.carry = daa_carry;
        end
        op_subtract_one_memory: begin
          mem_we_next = 1'b1;
          mem_wdata_next = dec_val;
          flags_next.zero = is_zero(dec_val);
        end
        op_subtract_one_to_acc: begin
          acc_next = dec_val;
          flags_next.zero = is_zero(dec_val);
        end
        op_add_one_memory: begin
          mem_we_next = 1'b1;
          mem_wdata_next = inc_val;
          flags_next.zero = is_zero(inc_val);
        end
        op_add_one_to_acc: begin
          acc_next = inc_val;
          flags_next.zero = is_zero(inc_val);
        end
        op_copy_mem_to_acc: acc_next = m;
        op_copy_imm_to_acc: acc_next = i_instr.imm;
        op_copy_acc_to_mem: begin
          mem_we_next = 1'b1;
          mem_wdata_next = acc_reg;
        end
        op_union_mem_to_acc: begin
          acc_next = or_mem_val;
          flags_next.zero = is_zero(or_mem_val);
        end
        op_union_imm_to_acc: begin
          acc_next = or_imm_val;
          flags_next.zero = is_zero(or_imm_val);
        end
        op_bitwise_union_to_memory: begin
          mem_we_next = 1'b1;
          mem_wdata_next = or_mem_val;
          flags_next.zero = is_zero(or_mem_val);
        end
        op_pop_with_value: acc_next = i_instr.imm;
        op_interrupt_exit: gie_next = 1'b1;
        op_rotate_left: begin
          mem_we_next = 1'b1;
          mem_wdata_next = rl_val;
        end
        op_rotate_left_to_acc: acc_next = rl_val;
        op_rotate_left_via_carry: begin
          mem_we_next = 1'b1;
          mem_wdata_next = rlc_val;
          flags_next.carry = m[7];
        end
        op_rotate_left_via_carry_to_acc: begin
          acc_next = rlc_val;
          flags_next.carry = m[7];
        end
        op_rotate_right: begin
          mem_we_next = 1'b1;
          mem_wdata_next = rr_val;
        end
        op_power_down: begin
          sleep_next = 1'b1;
          wdt_exp_next = 1'b0;
          stop_next = 1'b1;
        end
        default: acc_next = acc_reg;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_reg <= st_exec;
      acc_reg <= ACC_RESET;
      flags_reg <= '0;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= '0;
      pc_load_reg <= 1'b0;
      pc_value_reg <= '0;
      pop_reg <= 1'b0;
      irq_take_reg <= 1'b0;
      gie_reg <= 1'b0;
      sleep_reg <= 1'b0;
      wdt_exp_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
      clk_stop_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      mem_we_reg <= mem_we_next;
      mem_wdata_reg <= mem_wdata_next;
      gie_reg <= gie_next;
      sleep_reg <= sleep_next;
      wdt_exp_reg <= wdt_exp_next;
      clk_stop_reg <= stop_next;
      // low for the dummy slot after a branch and for good once stopped
      ready_reg <= !(take && is_branch) && !stop_next;
      wdt_clr_reg <= take && op == op_power_down;
      pc_load_reg <= take && is_branch;
      pop_reg <= take && is_branch && op != op_jump_absolute;
      pc_value_reg <= op == op_jump_absolute ? i_instr.addr : i_instr.stack_top;
      // pending interrupt taken in the dummy slot after the return
      irq_take_reg <= take && op == op_interrupt_exit && i_irq_pending;
      case (state_reg)
        st_exec: state_reg <= (take && is_branch) ? st_dummy : st_exec;
        st_dummy: state_reg <= st_exec;
        default: state_reg <= st_exec;
      endcase
    end
  end

  assign o_ready = ready_reg;
  assign o_acc = acc_reg;
  assign o_flags = flags_reg;
  assign o_mem_we = mem_we_reg;
  assign o_mem_wdata = mem_wdata_reg;
  assign o_pc_load = pc_load_reg;
  assign o_pc_value = pc_value_reg;
  assign o_stack_pop = pop_reg;
  assign o_irq_vector_take = irq_take_reg;
  assign o_global_irq_enable = gie_reg;
  assign o_sleep_entry_flag = sleep_reg;
  assign o_watchdog_expiry_flag = wdt_exp_reg;
  assign o_watchdog_clear = wdt_clr_reg;
  assign o_clock_stop = clk_stop_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_invert;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_invert_to_acc |=> acc_reg == ~$past(m) && !mem_we_reg;
  endproperty
  a_invert: assert property (p_invert) else $error("invert result wrong");
  property p_daa;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_bcd_adjust_store |=> mem_we_reg && flags_reg.zero == $past(flags_reg.zero);
  endproperty
  a_daa: assert property (p_daa) else $error("adjust store wrong");
  property p_dec;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_subtract_one_memory |=> mem_wdata_reg == $past(m) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_inc;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_add_one_to_acc |=> acc_reg == $past(m) + 8'h01 && !mem_we_reg;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_sleep;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_power_down |=> o_sleep_entry_flag && !o_watchdog_expiry_flag && o_watchdog_clear;
  endproperty
  a_sleep: assert property (p_sleep) else $error("power down flags wrong");
  property p_jump;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_jump_absolute |=> !o_ready ##1 o_ready;
  endproperty
  a_jump: assert property (p_jump) else $error("jump not two cycles");
  property p_interrupt_exit;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_interrupt_exit |=> o_global_irq_enable && o_stack_pop;
  endproperty
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt return wrong");
  property p_zero;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_union_imm_to_acc |=> flags_reg.zero == (acc_reg == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_rlc;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_rotate_left_via_carry_to_acc |=> flags_reg.carry == $past(m[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate carry wrong");
  property p_copy;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_copy_imm_to_acc |=> acc_reg == $past(i_instr.imm) && flags_reg == $past(flags_reg);
  endproperty
  a_copy: assert property (p_copy) else $error("copy result wrong");
  property p_union_mem;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_bitwise_union_to_memory |=> mem_we_reg && mem_wdata_reg == ($past(acc_reg) | $past(m))
      && acc_reg == $past(acc_reg);
  endproperty
  a_union_mem: assert property (p_union_mem) else $error("union to memory wrong");
  property p_idle;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_idle_op |=> acc_reg == $past(acc_reg) && flags_reg == $past(flags_reg) && !mem_we_reg
      && !pc_load_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");
  property p_ret;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_pop_program_counter |=> pc_load_reg && pop_reg
      && pc_value_reg == $past(i_instr.stack_top) && flags_reg == $past(flags_reg);
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_ret_val;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_pop_with_value |=> acc_reg == $past(i_instr.imm) && pc_value_reg == $past(i_instr.stack_top);
  endproperty
  a_ret_val: assert property (p_ret_val) else $error("return with value wrong");
  property p_irq_take;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_interrupt_exit && i_irq_pending |=> o_irq_vector_take;
  endproperty
  a_irq_take: assert property (p_irq_take) else $error("pending interrupt not taken");
  property p_rl;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_rotate_left |=> mem_wdata_reg == {$past(m[6:0]), $past(m[7])} && flags_reg == $past(flags_reg);
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left wrong");
  property p_rr;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      take && op == op_rotate_right |=> mem_wdata_reg == {$past(m[0]), $past(m[7:1])} && flags_reg == $past(flags_reg);
  endproperty
  a_rr: assert property (p_rr) else $error("rotate right wrong");
  property p_stop;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      clk_stop_reg |=> !o_ready && !mem_we_reg && !pc_load_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("work after power down");
  c_jump: cover property (@(posedge i_clk_sys) take && op == op_jump_absolute);
  c_stop: cover property (@(posedge i_clk_sys) take && op == op_power_down);
  c_daa: cover property (@(posedge i_clk_sys) take && op == op_bcd_adjust_store && daa_carry);
  c_irq: cover property (@(posedge i_clk_sys) take && op == op_interrupt_exit && i_irq_pending);
endmodule
`default_nettype wire

// ---- mem_stack_model.sv ----
// memory cell and stack model on the far side of the execute unit
// assumes the bench presets the operand and stack top before each instruction
`timescale 1ns/1ns
`default_nettype none
module mem_stack_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // bench preset
  input wire logic i_preset,
  input wire logic [7:0] i_preset_val,
  input wire logic [10:0] i_push_val,
  // execute unit side
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  input wire logic i_pop,
  output logic [7:0] o_mem,
  output logic [10:0] o_stack_top
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_mem <= 8'h00;
      o_stack_top <= 11'h000;
    end else if (i_preset) begin
      o_mem <= i_preset_val;
      o_stack_top <= i_push_val;
    end else begin
      if (i_we) o_mem <= i_wdata;
      // a popped entry is gone: show its inverse, never the stale value
      if (i_pop) o_stack_top <= ~o_stack_top;
    end
  end
endmodule
`default_nettype wire

// ---- accumulator_execute_unit_test.sv ----
// testbench: random instruction stream compared with a behavioural model
// assumes the memory and stack model file is compiled alongside
`timescale 1ns/1ns
`default_nettype none
module accumulator_execute_unit_test;
  import acc_exec_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 0, nrst = 0, valid = 0, irq = 0, pre = 0;
  logic rdy, we, ld, pop, take, gie, slp, wdx, wdc, stp;
  logic [7:0] acc, wd, pm, pv = 8'h00, imm = 8'h00;
  logic [10:0] pc, top, addr = 11'h000, tv = 11'h000;
  logic ec = 0, ez = 0, eg = 0;
  opcode_e op = op_idle_op;
  flags_s fl;
  instr_s ins;
  int ea = 0, mismatches = 0, total_checks = 0;
  logic [31:0] rnd = 32'hb67e1dbc;
  assign ins = {op, pm, imm, addr, top};
  accumulator_execute_unit accumulator_execute_unit_i (.i_clk_sys(clk), .i_nrst(nrst), .i_valid(valid),
    .i_instr(ins), .i_irq_pending(irq), .o_ready(rdy), .o_acc(acc), .o_flags(fl), .o_mem_we(we),
    .o_mem_wdata(wd), .o_pc_load(ld), .o_pc_value(pc), .o_stack_pop(pop), .o_irq_vector_take(take),
    .o_global_irq_enable(gie), .o_sleep_entry_flag(slp), .o_watchdog_expiry_flag(wdx),
    .o_watchdog_clear(wdc), .o_clock_stop(stp));
  mem_stack_model mem_stack_model_i (.i_clk_sys(clk), .i_nrst(nrst), .i_preset(pre), .i_preset_val(pv),
    .i_push_val(tv), .i_we(we), .i_wdata(wd), .i_pop(pop), .o_mem(pm), .o_stack_top(top));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    total_checks++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one instruction: drive, predict, compare
  task automatic run(input opcode_e o);
    logic [7:0] mv, iv;
    logic [10:0] av, sv;
    logic irqv, tomem, toacc, zu, br, pd;
    int res;
    rnd = lfsr(rnd);
    mv = rnd[7:0];
    iv = rnd[15:8];
    av = rnd[26:16];
    sv = rnd[26:16] ^ 11'h555;
    irqv = rnd[27];
    @(posedge clk);
    pre <= 1'b1;
    pv <= mv;
    tv <= sv;
    // the model shows the preset operand one edge later, so offer the instruction then
    @(posedge clk);
    pre <= 1'b0;
    op <= o;
    imm <= iv;
    addr <= av;
    irq <= irqv;
    valid <= 1'b1;
    case (o)
      op_invert_to_acc: res = ~mv;
      op_bcd_adjust_store: res = ea + (((ea & 15) > 9) ? 6 : 0) + ((ea > 159 || ec) ? 96 : 0);
      op_subtract_one_memory, op_subtract_one_to_acc: res = mv - 1;
      op_add_one_memory, op_add_one_to_acc: res = mv + 1;
      op_copy_mem_to_acc: res = mv;
      op_copy_imm_to_acc, op_pop_with_value: res = iv;
      op_union_mem_to_acc, op_bitwise_union_to_memory: res = ea | mv;
      op_union_imm_to_acc: res = ea | iv;
      op_rotate_left, op_rotate_left_to_acc: res = {mv[6:0], mv[7]};
      op_rotate_left_via_carry, op_rotate_left_via_carry_to_acc: res = {mv[6:0], ec};
      op_rotate_right: res = {mv[0], mv[7:1]};
      default: res = ea;
    endcase
    res = res & 255;
    tomem = o inside {op_bcd_adjust_store, op_subtract_one_memory, op_add_one_memory, op_copy_acc_to_mem,
      op_bitwise_union_to_memory, op_rotate_left, op_rotate_left_via_carry, op_rotate_right};
    toacc = o inside {op_invert_to_acc, op_subtract_one_to_acc, op_add_one_to_acc, op_copy_mem_to_acc,
      op_copy_imm_to_acc, op_union_mem_to_acc, op_union_imm_to_acc, op_pop_with_value, op_rotate_left_to_acc,
      op_rotate_left_via_carry_to_acc};
    zu = o inside {op_invert_to_acc, op_subtract_one_memory, op_subtract_one_to_acc, op_add_one_memory,
      op_add_one_to_acc, op_union_mem_to_acc, op_union_imm_to_acc, op_bitwise_union_to_memory};
    br = o inside {op_jump_absolute, op_pop_program_counter, op_pop_with_value, op_interrupt_exit};
    pd = (o == op_power_down);
    if (o == op_bcd_adjust_store) ec = ec | (ea > 159);
    if (o inside {op_rotate_left_via_carry, op_rotate_left_via_carry_to_acc}) ec = mv[7];
    if (zu) ez = (res == 0);
    if (toacc) ea = res;
    if (o == op_interrupt_exit) eg = 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    pre <= 1'b0;
    #1;
    chk("acc", ea, acc);
    chk("zero", ez, fl.zero);
    chk("carry", ec, fl.carry);
    chk("nibble", 0, fl.nibble_carry);
    chk("write", tomem, we);
    if (tomem) chk("wdata", res, wd);
    chk("pcload", br, ld);
    if (br) chk("pc", (o == op_jump_absolute) ? av : sv, pc);
    chk("pop", br && o != op_jump_absolute, pop);
    chk("take", o == op_interrupt_exit && irqv, take);
    chk("gie", eg, gie);
    chk("ready", !(br || pd), rdy);
    chk("sleep", pd, slp);
    chk("expiry", 0, wdx);
    chk("wdclear", pd, wdc);
    chk("clkstop", pd, stp);
    @(posedge clk);
    #1;
    if (tomem) chk("memcell", res, pm);
    chk("readyback", !pd, rdy);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
  initial begin
    opcode_e o;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      rnd = lfsr(rnd);
      o = opcode_e'(rnd[4:0] % 22);
      if (o == op_bcd_adjust_store) run(op_copy_imm_to_acc);
      run(o);
    end
    $display("test random stream done");
    run(op_power_down);
    @(posedge clk);
    op <= op_add_one_to_acc;
    valid <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("stopacc", ea, acc);
    chk("stopready", 0, rdy);
    chk("stopwrite", 0, we);
    $display("test power down done");
    end_sim();
  end
endmodule
`default_nettype wire
